// File: rtl/cmil_regs.sv
`timescale 1ns/1ps
module cmil_regs #(
	parameter logic [6:0] ADDR = cmil_pkg::DEV_ADDR
) (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        scl_link,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             int_n,
	input  wire logic        adapter_detected_flag,
	input  wire logic        battery_present_in,
	input  wire logic        mains_loss_in,
	input  wire logic        overtemp_hot_in,
	input  wire logic        adapter_above_pack_in,
	input  wire logic        temp_sense_above_91_in,
	input  wire logic        vdd_uvlo_in,
	output logic             charger_enable,
	output logic      [15:0] charge_voltage_setpoint,
	output logic      [15:0] charge_current_setpoint,
	output logic      [15:0] input_limit_setpoint,
	output logic      [15:0] input_limit_ma,
	output logic             adapter_path_switch,
	output logic             pack_path_switch
);
	logic [cmil_pkg::SYNC_W-1:0] pin_raw;
	logic [cmil_pkg::SYNC_W-1:0] pin_s;
	logic [cmil_pkg::SYNC_W-1:0] pin_p_q;
	logic [1:0]                  arm_q;
	logic                        armed;
	logic [7:0]                  shift_q;
	logic                        scl_rise;
	logic                        scl_fall;
	logic                        start_ev;
	logic                        stop_ev;
	logic                        byte_done;
	logic                        addr_hit;
	logic [3:0]                  bit_cnt_q;
	cmil_pkg::cmil_state_t       state_q;
	logic                        ack_q;
	logic                        sda_oe_q;
	logic [7:0]                  cmd_q;
	logic [15:0]                 wd_q;
	logic                        commit;
	logic                        wr_mode;
	logic                        wr_ilim;
	logic                        charge_block_q;
	logic                        por_hold_q;
	logic                        adp_mask_q;
	logic                        bat_mask_q;
	logic                        pwr_mask_q;
	logic                        relearn_q;
	logic                        halts_q;
	logic                        ot_latch_q;
	logic                        bat_fell;
	logic                        irq_ev;
	logic                        int_n_q;
	logic                        path_adp;
	logic                        chg_en_q;
	logic                        adp_sw_q;
	logic                        pack_sw_q;
	logic [15:0]                 vchg_q;
	logic [15:0]                 ichg_q;
	logic [15:0]                 ilim_code_q;
	logic [15:0]                 ilim_code_d;
	logic [15:0]                 ilim_ma_q;
	logic [15:0]                 ilim_ma_d;
	logic [15:0]                 ilim_eff;

	assign pin_raw = {vdd_uvlo_in, temp_sense_above_91_in, adapter_above_pack_in, overtemp_hot_in,
		mains_loss_in, battery_present_in, adapter_detected_flag, sda_i, scl_link};

	cmil_sync #(
		.W (cmil_pkg::SYNC_W)
	) u_sync (
		.mclk (mclk),
		.srst (srst),
		.d    (pin_raw),
		.q    (pin_s)
	);

	cmil_link_shift #(
		.W (8)
	) u_shift (
		.scl_link (scl_link),
		.sda_i    (sda_i),
		.shift_q  (shift_q)
	);

	// Edges are ignored until the synchronisers hold real pin levels
	always_ff @(posedge mclk) begin
		if (srst) begin
			arm_q   <= '0;
			pin_p_q <= '0;
		end else begin
			if (arm_q != cmil_pkg::ARM_DONE) begin
				arm_q <= arm_q + 2'h1;
			end
			pin_p_q <= pin_s;
		end
	end

	assign armed    = (arm_q == cmil_pkg::ARM_DONE);
	assign scl_rise = armed && pin_s[cmil_pkg::SI_SCL] && !pin_p_q[cmil_pkg::SI_SCL];
	assign scl_fall = armed && !pin_s[cmil_pkg::SI_SCL] && pin_p_q[cmil_pkg::SI_SCL];
	assign start_ev = armed && pin_s[cmil_pkg::SI_SCL] && pin_p_q[cmil_pkg::SI_SCL]
		&& !pin_s[cmil_pkg::SI_SDA] && pin_p_q[cmil_pkg::SI_SDA];
	assign stop_ev  = armed && pin_s[cmil_pkg::SI_SCL] && pin_p_q[cmil_pkg::SI_SCL]
		&& pin_s[cmil_pkg::SI_SDA] && !pin_p_q[cmil_pkg::SI_SDA];
	assign byte_done = scl_rise && (bit_cnt_q == cmil_pkg::BIT_LAST);
	assign addr_hit  = (shift_q[7:1] == ADDR) && !shift_q[0];

	always_ff @(posedge mclk) begin
		if (srst || start_ev) begin
			bit_cnt_q <= '0;
		end else if (scl_rise) begin
			bit_cnt_q <= (bit_cnt_q == cmil_pkg::BIT_ACK) ? 4'h0 : bit_cnt_q + 4'h1;
		end
	end

	// Frame walk: address, command, low data byte, high data byte
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= cmil_pkg::ST_IDLE;
		end else if (start_ev) begin
			state_q <= cmil_pkg::ST_ADDR;
		end else if (stop_ev) begin
			state_q <= cmil_pkg::ST_IDLE;
		end else if (byte_done) begin
			case (state_q)
				cmil_pkg::ST_ADDR: state_q <= addr_hit ? cmil_pkg::ST_CMD : cmil_pkg::ST_SKIP;
				cmil_pkg::ST_CMD:  state_q <= cmil_pkg::ST_LO;
				cmil_pkg::ST_LO:   state_q <= cmil_pkg::ST_HI;
				cmil_pkg::ST_HI:   state_q <= cmil_pkg::ST_END;
				cmil_pkg::ST_END:  state_q <= cmil_pkg::ST_SKIP;
				default:           state_q <= state_q;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst || start_ev) begin
			ack_q <= 1'b0;
		end else if (byte_done) begin
			ack_q <= ((state_q == cmil_pkg::ST_ADDR) && addr_hit) || (state_q == cmil_pkg::ST_CMD)
				|| (state_q == cmil_pkg::ST_LO) || (state_q == cmil_pkg::ST_HI);
		end
	end

	// Pull data low through the ninth clock of an accepted byte
	always_ff @(posedge mclk) begin
		if (srst || start_ev || stop_ev) begin
			sda_oe_q <= 1'b0;
		end else if (scl_fall) begin
			sda_oe_q <= (bit_cnt_q == cmil_pkg::BIT_ACK) && ack_q;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			cmd_q <= '0;
			wd_q  <= '0;
		end else if (byte_done) begin
			case (state_q)
				cmil_pkg::ST_CMD: cmd_q <= shift_q;
				cmil_pkg::ST_LO:  wd_q[7:0] <= shift_q;
				cmil_pkg::ST_HI:  wd_q[15:8] <= shift_q;
				default:          cmd_q <= cmd_q;
			endcase
		end
	end

	// Words take effect only at the stop of a complete Write-Word frame
	assign commit  = stop_ev && (state_q == cmil_pkg::ST_END);
	assign wr_mode = commit && (cmd_q == cmil_pkg::CMD_MODE);
	assign wr_ilim = commit && (cmd_q == cmil_pkg::CMD_ILIM);

	// Mode word; unused bit positions are simply never looked at
	always_ff @(posedge mclk) begin
		if (srst) begin
			charge_block_q <= cmil_pkg::BLOCK_RST;
		end else if (wr_mode) begin
			charge_block_q <= wd_q[cmil_pkg::MB_BLOCK];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			por_hold_q <= 1'b0;
		end else if (wr_mode) begin
			por_hold_q <= wd_q[cmil_pkg::MB_POR];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			adp_mask_q <= cmil_pkg::MASK_RST;
			bat_mask_q <= cmil_pkg::MASK_RST;
			pwr_mask_q <= cmil_pkg::MASK_RST;
			relearn_q  <= cmil_pkg::RELEARN_RST;
		end else if (wr_mode) begin
			adp_mask_q <= wd_q[cmil_pkg::MB_ADP_MASK];
			bat_mask_q <= wd_q[cmil_pkg::MB_BAT_MASK];
			pwr_mask_q <= wd_q[cmil_pkg::MB_PWR_MASK];
			relearn_q  <= wd_q[cmil_pkg::MB_RELEARN];
		end
	end

	assign bat_fell = armed && !pin_s[cmil_pkg::SI_BAT] && pin_p_q[cmil_pkg::SI_BAT];

	// Battery removal restores the stop, even against a write in the same cycle
	always_ff @(posedge mclk) begin
		if (srst || bat_fell) begin
			halts_q <= cmil_pkg::HALT_RST;
		end else if (wr_mode) begin
			halts_q <= wd_q[cmil_pkg::MB_HALT];
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ot_latch_q <= 1'b0;
		end else if (pin_s[cmil_pkg::SI_HOT]) begin
			ot_latch_q <= 1'b1;
		end else if ((wr_mode && wd_q[cmil_pkg::MB_POR]) || !pin_s[cmil_pkg::SI_BAT]) begin
			ot_latch_q <= 1'b0;
		end
	end

	// Zeroing takes priority when both bits arrive in one word
	always_ff @(posedge mclk) begin
		if (srst) begin
			vchg_q <= cmil_pkg::VCHG_RST;
			ichg_q <= cmil_pkg::ICHG_RST;
		end else if (wr_mode && wd_q[cmil_pkg::MB_ZERO]) begin
			vchg_q <= cmil_pkg::SETP_ZERO;
			ichg_q <= cmil_pkg::SETP_ZERO;
		end else if (wr_mode && wd_q[cmil_pkg::MB_POR]) begin
			vchg_q <= cmil_pkg::VCHG_RST;
			ichg_q <= cmil_pkg::ICHG_RST;
		end
	end

	always_comb begin
		ilim_code_d = ilim_code_q;
		if (pin_s[cmil_pkg::SI_UVLO] || (wr_mode && wd_q[cmil_pkg::MB_POR])) begin
			ilim_code_d = cmil_pkg::ILIM_RST;
		end else if (wr_ilim) begin
			ilim_code_d = wd_q;
		end
		ilim_eff = ilim_code_d & cmil_pkg::ILIM_MASK;
		if (ilim_eff > cmil_pkg::ILIM_MAX_MA) begin
			ilim_ma_d = cmil_pkg::ILIM_MAX_MA;
		end else if ((ilim_code_d[12:0] != 13'h0000) && (ilim_eff < cmil_pkg::ILIM_MIN_MA)) begin
			ilim_ma_d = cmil_pkg::ILIM_MIN_MA;
		end else begin
			ilim_ma_d = ilim_eff;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			ilim_code_q <= cmil_pkg::ILIM_RST;
			ilim_ma_q   <= cmil_pkg::ILIM_MIN_MA;
		end else begin
			ilim_code_q <= ilim_code_d;
			ilim_ma_q   <= ilim_ma_d;
		end
	end

	assign irq_ev = armed && (
		((pin_s[cmil_pkg::SI_ADP] != pin_p_q[cmil_pkg::SI_ADP]) && !adp_mask_q) ||
		((pin_s[cmil_pkg::SI_BAT] != pin_p_q[cmil_pkg::SI_BAT]) && !bat_mask_q) ||
		((pin_s[cmil_pkg::SI_PWR] != pin_p_q[cmil_pkg::SI_PWR]) && !pwr_mask_q));

	// Request held until the host completes a write; a new cause wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			int_n_q <= 1'b1;
		end else if (irq_ev) begin
			int_n_q <= 1'b0;
		end else if (commit) begin
			int_n_q <= 1'b1;
		end
	end

	assign path_adp = pin_s[cmil_pkg::SI_ABOVE] && !(relearn_q && !pin_s[cmil_pkg::SI_T91]);

	// Switch outputs are pin levels: low turns a source on
	always_ff @(posedge mclk) begin
		if (srst) begin
			adp_sw_q  <= 1'b1;
			pack_sw_q <= 1'b0;
		end else begin
			adp_sw_q  <= !path_adp;
			pack_sw_q <= path_adp;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			chg_en_q <= 1'b0;
		end else begin
			chg_en_q <= !charge_block_q && !(ot_latch_q && halts_q) && !por_hold_q;
		end
	end

	assign sda_o                   = 1'b0;
	assign sda_oe                  = sda_oe_q;
	assign int_n                   = int_n_q;
	assign charger_enable          = chg_en_q;
	assign charge_voltage_setpoint = vchg_q;
	assign charge_current_setpoint = ichg_q;
	assign input_limit_setpoint    = ilim_code_q;
	assign input_limit_ma          = ilim_ma_q;
	assign adapter_path_switch     = adp_sw_q;
	assign pack_path_switch        = pack_sw_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	ilim_clamp_a: assert property (wr_ilim && !pin_s[cmil_pkg::SI_UVLO]
		&& ((wd_q & cmil_pkg::ILIM_MASK) > cmil_pkg::ILIM_MAX_MA) |=> input_limit_ma == 16'h2AFC)
		else $error("input limit not clamped");
	ilim_floor_a: assert property (wr_ilim && !pin_s[cmil_pkg::SI_UVLO] && (wd_q[12:0] != 13'h0000)
		&& (wd_q[12:7] == 6'h00) |=> input_limit_ma == 16'h0100)
		else $error("small input limit not raised");
	ilim_mask_a: assert property (wr_ilim && !pin_s[cmil_pkg::SI_UVLO] && (wd_q[12:8] != 5'h00)
		&& (wd_q[12:7] <= 6'h2A) |=> input_limit_ma == {3'h0, $past(wd_q[12:7]), 7'h00})
		else $error("input limit bits not masked");
	ilim_uvlo_a: assert property (pin_s[cmil_pkg::SI_UVLO] |=> input_limit_setpoint == 16'h0080
		&& input_limit_ma == 16'h0100)
		else $error("undervoltage did not reload input limit");
	block_latch_a: assert property (wr_mode |=> charge_block_q == $past(wd_q[0]) ##1
		(!charge_block_q || !charger_enable))
		else $error("charge block latch wrong");
	zero_setp_a: assert property (wr_mode && wd_q[3] |=> charge_current_setpoint == 16'h0000
		&& charge_voltage_setpoint == 16'h0000)
		else $error("setpoints not zeroed");
	por_load_a: assert property (wr_mode && wd_q[2] && !wd_q[3] |=> charge_voltage_setpoint == 16'h4B00
		&& charge_current_setpoint == 16'h0080 && input_limit_setpoint == 16'h0080)
		else $error("reset-to-defaults did not reload");
	adp_irq_a: assert property (armed && $changed(pin_s[cmil_pkg::SI_ADP]) && !adp_mask_q |=> !int_n)
		else $error("adapter change raised no interrupt");
	pwr_irq_a: assert property (armed && $changed(pin_s[cmil_pkg::SI_PWR]) && !pwr_mask_q |=> !int_n)
		else $error("mains-loss change raised no interrupt");
	overtemp_halts_charger_a: assert property (ot_latch_q && halts_q |=> !charger_enable)
		else $error("overtemperature did not stop charger");
	halt_restore_a: assert property (bat_fell |=> halts_q)
		else $error("stop bit not restored on removal");
	path_pick_a: assert property (!pin_s[cmil_pkg::SI_ABOVE] |=> pack_path_switch == 1'b0
		&& adapter_path_switch == 1'b1)
		else $error("battery path not selected");
	relearn_path_a: assert property (pin_s[cmil_pkg::SI_ABOVE] && relearn_q && !pin_s[cmil_pkg::SI_T91]
		|=> !pack_path_switch && adapter_path_switch)
		else $error("relearn path wrong");
endmodule

// File: common/cmil_pkg.sv
package cmil_pkg;
	localparam logic [7:0]  CMD_MODE     = 8'h12;
	localparam logic [7:0]  CMD_ILIM     = 8'h3F;
	localparam logic [6:0]  DEV_ADDR     = 7'h09;
	localparam logic [15:0] ILIM_RST     = 16'h0080;
	localparam logic [15:0] ILIM_MASK    = 16'h1F80;
	localparam logic [15:0] ILIM_MAX_MA  = 16'h2AFC;
	localparam logic [15:0] ILIM_MIN_MA  = 16'h0100;
	localparam logic [15:0] VCHG_RST     = 16'h4B00;
	localparam logic [15:0] ICHG_RST     = 16'h0080;
	localparam logic [15:0] SETP_ZERO    = 16'h0000;
	localparam logic        HALT_RST     = 1'b1;
	localparam logic        MASK_RST     = 1'b0;
	localparam logic        RELEARN_RST  = 1'b0;
	localparam logic        BLOCK_RST    = 1'b0;
	localparam int          MB_BLOCK     = 0;
	localparam int          MB_POR       = 2;
	localparam int          MB_ZERO      = 3;
	localparam int          MB_ADP_MASK  = 4;
	localparam int          MB_BAT_MASK  = 5;
	localparam int          MB_PWR_MASK  = 6;
	localparam int          MB_RELEARN   = 8;
	localparam int          MB_HALT      = 10;
	localparam logic [3:0]  BIT_LAST     = 4'h7;
	localparam logic [3:0]  BIT_ACK      = 4'h8;
	localparam logic [1:0]  ARM_DONE     = 2'h3;
	localparam int          SI_SCL       = 0;
	localparam int          SI_SDA       = 1;
	localparam int          SI_ADP       = 2;
	localparam int          SI_BAT       = 3;
	localparam int          SI_PWR       = 4;
	localparam int          SI_HOT       = 5;
	localparam int          SI_ABOVE     = 6;
	localparam int          SI_T91       = 7;
	localparam int          SI_UVLO      = 8;
	localparam int          SYNC_W       = 9;
	typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CMD, ST_LO, ST_HI, ST_END, ST_SKIP} cmil_state_t;
endpackage

// File: rtl/cmil_sync.sv
`timescale 1ns/1ps
module cmil_sync #(
	parameter int W = 1
) (
	input  wire logic         mclk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge mclk) begin
		if (srst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// File: rtl/cmil_link_shift.sv
`timescale 1ns/1ps
module cmil_link_shift #(
	parameter int W = 8
) (
	input  wire logic         scl_link,
	input  wire logic         sda_i,
	output logic      [W-1:0] shift_q
);
	// Held stable from one link edge to the next, read after the edge is seen
	always_ff @(posedge scl_link) begin
		shift_q <= {shift_q[W-2:0], sda_i};
	end
endmodule

// File: test/cmil_host_model.sv
`timescale 1ns/1ps
module cmil_host_model (
	input  wire logic lclk,
	input  wire logic sda_line,
	output logic      scl,
	output logic      sda_low
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge lclk);
	endtask

	// Data moves one tick after SCL falls; sampled at the end of the high phase
	task automatic put_bit(input logic b, output logic seen);
		sda_low <= !b;
		tick(3);
		scl <= 1'b1;
		tick(3);
		seen = sda_line;
		scl <= 1'b0;
		tick(1);
	endtask

	// Address, command, data low, data high, then a spare byte only when nb asks for it
	task automatic frame(input logic [7:0] a, input logic [7:0] c, input logic [15:0] d, input int nb,
			output logic [4:0] nack);
		logic [7:0] by [5];
		logic       s;
		by = '{a, c, d[7:0], d[15:8], 8'hA5};
		nack = 5'h1F;
		sda_low <= 1'b1;
		tick(3);
		scl <= 1'b0;
		tick(1);
		for (int i = 0; i < nb; i++) begin
			for (int k = 7; k >= 0; k--) begin
				put_bit(by[i][k], s);
			end
			put_bit(1'b1, s);
			nack[i] = s;
		end
		sda_low <= 1'b1;
		tick(3);
		scl <= 1'b1;
		tick(3);
		sda_low <= 1'b0;
		tick(3);
	endtask
endmodule

// File: test/charger_mode_input_limit_regs_tb.sv
`timescale 1ns/1ps
module charger_mode_input_limit_regs_tb;
	typedef struct packed {
		logic [7:0]  cmd;
		logic [15:0] data;
		logic [15:0] code;
		logic [15:0] ma;
		logic [15:0] volt;
		logic [15:0] curr;
		logic        en;
	} cmil_row_t;

	logic        mclk, srst, lclk, scl, sda_low, sda_line, sda_o, sda_oe, int_n;
	logic        adp, bat, mains, hot, above, t91, uvlo;
	logic        charger_enable, adapter_path_switch, pack_path_switch;
	logic [15:0] charge_voltage_setpoint, charge_current_setpoint, input_limit_setpoint, input_limit_ma;
	logic [4:0]  nk;
	logic [7:0]  aw;
	int          miscompares = 0;
	int          comparisons = 0;
	cmil_row_t   rows [14] = '{
		'{8'h3F, 16'h0200, 16'h0200, 16'h0200, 16'h4B00, 16'h0080, 1'b1},
		'{8'h3F, 16'h0001, 16'h0001, 16'h0100, 16'h4B00, 16'h0080, 1'b1},
		'{8'h3F, 16'h0000, 16'h0000, 16'h0000, 16'h4B00, 16'h0080, 1'b1},
		'{8'h3F, 16'hE27F, 16'hE27F, 16'h0200, 16'h4B00, 16'h0080, 1'b1},
		'{8'h3F, 16'hFFFF, 16'hFFFF, 16'h1F80, 16'h4B00, 16'h0080, 1'b1},
		'{8'h3F, 16'h0180, 16'h0180, 16'h0180, 16'h4B00, 16'h0080, 1'b1},
		'{8'h20, 16'h1234, 16'h0180, 16'h0180, 16'h4B00, 16'h0080, 1'b1},
		'{8'h12, 16'h0001, 16'h0180, 16'h0180, 16'h4B00, 16'h0080, 1'b0},
		'{8'h12, 16'h0000, 16'h0180, 16'h0180, 16'h4B00, 16'h0080, 1'b1},
		'{8'h12, 16'h0008, 16'h0180, 16'h0180, 16'h0000, 16'h0000, 1'b1},
		'{8'h12, 16'h0004, 16'h0080, 16'h0100, 16'h4B00, 16'h0080, 1'b0},
		'{8'h12, 16'h0000, 16'h0080, 16'h0100, 16'h4B00, 16'h0080, 1'b1},
		'{8'h12, 16'hFA82, 16'h0080, 16'h0100, 16'h4B00, 16'h0080, 1'b1},
		'{8'h12, 16'h0400, 16'h0080, 16'h0100, 16'h4B00, 16'h0080, 1'b1}
	};

	assign aw = {cmil_pkg::DEV_ADDR, 1'b0};
	// Open-drain data line with pull-up
	assign sda_line = !(sda_low || (sda_oe && !sda_o));

	initial mclk = 1'b0;
	always #5 mclk = ~mclk;
	initial lclk = 1'b0;
	always #24 lclk = ~lclk;

	cmil_host_model host (
		.lclk     (lclk),
		.sda_line (sda_line),
		.scl      (scl),
		.sda_low  (sda_low)
	);

	cmil_regs uut (
		.mclk                    (mclk),
		.srst                    (srst),
		.scl_link                (scl),
		.sda_i                   (sda_line),
		.sda_o                   (sda_o),
		.sda_oe                  (sda_oe),
		.int_n                   (int_n),
		.adapter_detected_flag   (adp),
		.battery_present_in      (bat),
		.mains_loss_in           (mains),
		.overtemp_hot_in         (hot),
		.adapter_above_pack_in   (above),
		.temp_sense_above_91_in  (t91),
		.vdd_uvlo_in             (uvlo),
		.charger_enable          (charger_enable),
		.charge_voltage_setpoint (charge_voltage_setpoint),
		.charge_current_setpoint (charge_current_setpoint),
		.input_limit_setpoint    (input_limit_setpoint),
		.input_limit_ma          (input_limit_ma),
		.adapter_path_switch     (adapter_path_switch),
		.pack_path_switch        (pack_path_switch)
	);

	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic settle;
		repeat (8) @(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] c, input logic [15:0] d);
		host.frame(aw, c, d, 4, nk);
		settle;
	endtask

	task automatic reset_and_check;
		@(posedge mclk) srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		settle;
		chk("ilim_code", input_limit_setpoint, 16'h0080);
		chk("ilim_ma", input_limit_ma, 16'h0100);
		chk("volt", charge_voltage_setpoint, 16'h4B00);
		chk("curr", charge_current_setpoint, 16'h0080);
		chk("int_n", 16'(int_n), 16'h0001);
		chk("enable", 16'(charger_enable), 16'h0001);
	endtask

	task automatic test_done;
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (80000) @(posedge mclk);
		miscompares++;
		test_done;
	end

	initial begin
		srst = 1'b1;
		{adp, bat, mains, hot, above, t91, uvlo} = 7'b1100000;
		reset_and_check;
		foreach (rows[i]) begin
			wr(rows[i].cmd, rows[i].data);
			chk("ack", 16'(nk[3:0]), 16'h0000);
			chk("ilim_code", input_limit_setpoint, rows[i].code);
			chk("ilim_ma", input_limit_ma, rows[i].ma);
			chk("volt", charge_voltage_setpoint, rows[i].volt);
			chk("curr", charge_current_setpoint, rows[i].curr);
			chk("enable", 16'(charger_enable), 16'(rows[i].en));
		end
		@(posedge mclk) mains <= 1'b1;
		settle;
		chk("int_n", 16'(int_n), 16'h0000);
		wr(8'h12, 16'h0410);
		chk("int_n", 16'(int_n), 16'h0001);
		@(posedge mclk) adp <= 1'b0;
		settle;
		chk("int_n", 16'(int_n), 16'h0001);
		@(posedge mclk) hot <= 1'b1;
		@(posedge mclk) hot <= 1'b0;
		settle;
		chk("enable", 16'(charger_enable), 16'h0000);
		wr(8'h12, 16'h0010);
		chk("enable", 16'(charger_enable), 16'h0001);
		@(posedge mclk) bat <= 1'b0;
		settle;
		chk("int_n", 16'(int_n), 16'h0000);
		@(posedge mclk) bat <= 1'b1;
		settle;
		chk("enable", 16'(charger_enable), 16'h0001);
		@(posedge mclk) hot <= 1'b1;
		@(posedge mclk) hot <= 1'b0;
		settle;
		chk("enable", 16'(charger_enable), 16'h0000);
		wr(8'h12, 16'h0414);
		chk("enable", 16'(charger_enable), 16'h0000);
		wr(8'h12, 16'h0410);
		chk("enable", 16'(charger_enable), 16'h0001);
		@(posedge mclk) above <= 1'b1;
		settle;
		chk("paths", 16'({adapter_path_switch, pack_path_switch}), 16'h0001);
		@(posedge mclk) above <= 1'b0;
		settle;
		chk("paths", 16'({adapter_path_switch, pack_path_switch}), 16'h0002);
		@(posedge mclk) above <= 1'b1;
		wr(8'h12, 16'h0500);
		chk("paths", 16'({adapter_path_switch, pack_path_switch}), 16'h0002);
		@(posedge mclk) t91 <= 1'b1;
		settle;
		chk("paths", 16'({adapter_path_switch, pack_path_switch}), 16'h0001);
		@(posedge mclk) adp <= 1'b1;
		settle;
		chk("int_n", 16'(int_n), 16'h0000);
		wr(8'h12, 16'h0570);
		chk("int_n", 16'(int_n), 16'h0001);
		@(posedge mclk) mains <= 1'b0;
		settle;
		chk("int_n", 16'(int_n), 16'h0001);
		@(posedge mclk) bat <= 1'b0;
		settle;
		@(posedge mclk) bat <= 1'b1;
		settle;
		chk("int_n", 16'(int_n), 16'h0001);
		wr(8'h3F, 16'h0400);
		@(posedge mclk) uvlo <= 1'b1;
		settle;
		chk("ilim_code", input_limit_setpoint, 16'h0080);
		chk("ilim_ma", input_limit_ma, 16'h0100);
		@(posedge mclk) uvlo <= 1'b0;
		host.frame(aw ^ 8'h02, 8'h3F, 16'h0800, 4, nk);
		settle;
		chk("addr_nack", 16'(nk[0]), 16'h0001);
		host.frame(aw, 8'h3F, 16'h0800, 5, nk);
		settle;
		chk("extra_nack", 16'(nk[4]), 16'h0001);
		chk("ilim_code", input_limit_setpoint, 16'h0080);
		wr(8'h3F, 16'h0C00);
		reset_and_check;
		test_done;
	end
endmodule
